// File: pcd_defines.svh
// constants for the pulse count dimming decoder
// assumes a 25 MHz system clock (40 ns period)
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

`define PCD_CLK_MHZ 25
`define PCD_LVL_W 5
`define PCD_CNT_W 17
`define PCD_LVL_FULL 5'h1f
`define PCD_CNT_ZERO 5'h00
`define PCD_CNT_ONE 5'h01
// times as printed
`define PCD_PROG_LOW_MIN_US 1
`define PCD_SHDN_MIN_MS 2
`define PCD_SHDN_TYP_MS 3
`define PCD_SHDN_MAX_MS 5
// cycle counts: minimum rounds up
`define PCD_PROG_LOW_CYC (`PCD_PROG_LOW_MIN_US * `PCD_CLK_MHZ)
`define PCD_SHDN_TYP_CYC (`PCD_SHDN_TYP_MS * 1000 * `PCD_CLK_MHZ)
`define PCD_SHDN_MIN_CYC (`PCD_SHDN_MIN_MS * 1000 * `PCD_CLK_MHZ)

`endif

// File: pcd_pkg.sv
// types for the pulse count dimming decoder
// used with pcd_defines.svh
package pcd_pkg;
	typedef enum logic [1:0] {PCD_SHUTDOWN, PCD_ACTIVE, PCD_LOW} pcd_state_t;
endpackage

// File: pcd_pin_sync.sv
// three-stage synchroniser for the dimming pin
// assumes pin is asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "pcd_defines.svh"

module pcd_pin_sync
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// pin and clean level
	input wire logic pin_in,
	output logic level_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// first stage read only by second
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_out <= 1'b0;
		end
		else
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level_out <= s3_r;
		end
	end
endmodule // pcd_pin_sync
`default_nettype wire

// File: pcd_decoder.sv
// pulse count dimming decoder top
// assumes enable_dimming_input from a host pin, supply_lockout from an analog comparator
`timescale 1ns/10ps
`default_nettype none
`include "pcd_defines.svh"

module pcd_decoder
#(
	parameter int SHDN_CYC = `PCD_SHDN_TYP_CYC
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// host pin and supply monitor
	input wire logic enable_dimming_input,
	input wire logic supply_lockout,
	// current code to the sink dacs, 31 = full scale, 0 = off
	output logic [`PCD_LVL_W-1:0] current_code,
	// per channel sink enable, low means high impedance
	output logic [3:0] sink_enable,
	output logic device_enabled
);
	////////////////////////////////////////////////////////////////////////
	logic pin_lvl;
	logic pin_d_r;
	logic lock_s1_r;
	logic lock_s2_r;
	logic lock_s3_r;
	logic lock_r;
	logic [`PCD_CNT_W-1:0] tmr_r;
	logic [`PCD_CNT_W-1:0] tmr_nxt;
	logic [`PCD_LVL_W-1:0] count_r;
	logic [`PCD_LVL_W-1:0] count_nxt;
	pcd_pkg::pcd_state_t state_r;
	pcd_pkg::pcd_state_t state_nxt;

	pcd_pin_sync u_sync
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin_in(enable_dimming_input),
		.level_out(pin_lvl)
	);

	// lockout comparator is asynchronous too
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lock_s1_r <= 1'b1;
			lock_s2_r <= 1'b1;
			lock_s3_r <= 1'b1;
			lock_r <= 1'b1;
		end
		else
		begin
			lock_s1_r <= supply_lockout;
			lock_s2_r <= lock_s1_r;
			lock_s3_r <= lock_s2_r;
			if (lock_s2_r == lock_s3_r)
				lock_r <= lock_s3_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire pin_edge = pin_lvl != pin_d_r;
	wire pin_rise = pin_lvl & ~pin_d_r;
	// saturate so a long low never wraps back below the threshold
	wire tmr_sat = tmr_r == {`PCD_CNT_W{1'b1}};
	wire low_long = tmr_r >= `PCD_CNT_W'(SHDN_CYC - 1);
	// short glitches never counted; timer is one less than the low width at the rising edge
	wire low_valid = tmr_r >= `PCD_CNT_W'(`PCD_PROG_LOW_CYC - 1);
	wire [`PCD_LVL_W-1:0] count_inc = count_r + `PCD_CNT_ONE;

	assign tmr_nxt = pin_edge ? '0 : (tmr_sat ? tmr_r : tmr_r + `PCD_CNT_W'(1));

	always_comb
	begin
		state_nxt = state_r;
		count_nxt = count_r;
		if (lock_r)
		begin
			state_nxt = pcd_pkg::PCD_SHUTDOWN;
			count_nxt = `PCD_CNT_ZERO;
		end
		else
		begin
			case (state_r)
				pcd_pkg::PCD_SHUTDOWN:
				begin
					count_nxt = `PCD_CNT_ZERO;
					if (pin_lvl)
						state_nxt = pcd_pkg::PCD_ACTIVE;
				end
				pcd_pkg::PCD_ACTIVE:
				begin
					if (!pin_lvl)
						state_nxt = pcd_pkg::PCD_LOW;
				end
				pcd_pkg::PCD_LOW:
				begin
					if (pin_lvl)
					begin
						state_nxt = pcd_pkg::PCD_ACTIVE;
						if (low_valid)
							count_nxt = count_inc;
					end
					else if (low_long)
					begin
						state_nxt = pcd_pkg::PCD_SHUTDOWN;
						count_nxt = `PCD_CNT_ZERO;
					end
				end
				default:
				begin
					state_nxt = pcd_pkg::PCD_SHUTDOWN;
					count_nxt = `PCD_CNT_ZERO;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire run_nxt = state_nxt != pcd_pkg::PCD_SHUTDOWN;
	// code is 31 - n: the five-bit count maps to 32 levels, wrap at 32 is free
	wire [`PCD_LVL_W-1:0] code_nxt = `PCD_LVL_FULL - count_nxt;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= pcd_pkg::PCD_SHUTDOWN;
			count_r <= `PCD_CNT_ZERO;
			tmr_r <= '0;
			pin_d_r <= 1'b0;
			current_code <= `PCD_CNT_ZERO;
			sink_enable <= 4'h0;
			device_enabled <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			count_r <= count_nxt;
			tmr_r <= tmr_nxt;
			pin_d_r <= pin_lvl;
			current_code <= run_nxt ? code_nxt : `PCD_CNT_ZERO;
			sink_enable <= {4{run_nxt}};
			device_enabled <= run_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_lockout;
		@(posedge clk_sys) disable iff (!reset_n)
		lock_r |=> (sink_enable == 4'h0) && (count_r == `PCD_CNT_ZERO);
	endproperty
	a_lockout: assert property (p_lockout) else $error("lockout left sinks on");

	property p_enable_full;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == pcd_pkg::PCD_SHUTDOWN) && pin_lvl && !lock_r
		|=> device_enabled && (current_code == `PCD_LVL_FULL);
	endproperty
	a_enable_full: assert property (p_enable_full) else $error("enable not full");

	property p_shdn_timeout;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == pcd_pkg::PCD_LOW) && !pin_lvl && low_long |=> !device_enabled;
	endproperty
	a_shdn_timeout: assert property (p_shdn_timeout) else $error("no shutdown");

	property p_hiz;
		@(posedge clk_sys) disable iff (!reset_n)
		!device_enabled |-> (sink_enable == 4'h0) && (current_code == `PCD_CNT_ZERO);
	endproperty
	a_hiz: assert property (p_hiz) else $error("sinks live in shutdown");

	property p_code;
		@(posedge clk_sys) disable iff (!reset_n)
		device_enabled |-> current_code == `PCD_LVL_FULL - $past(count_nxt);
	endproperty
	a_code: assert property (p_code) else $error("code mismatch");

	property p_step;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == pcd_pkg::PCD_LOW) && pin_lvl && low_valid && !lock_r
		|=> count_r == $past(count_r) + `PCD_CNT_ONE;
	endproperty
	a_step: assert property (p_step) else $error("missed step");

	property p_wrap;
		@(posedge clk_sys) disable iff (!reset_n)
		(count_r == `PCD_LVL_FULL) && (count_nxt != `PCD_LVL_FULL) && !lock_r
		&& (state_r == pcd_pkg::PCD_LOW) && pin_lvl
		|=> current_code == `PCD_LVL_FULL;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap to full");

	property p_glitch;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == pcd_pkg::PCD_LOW) && pin_lvl && !low_valid && !lock_r |=> $stable(count_r);
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch counted");

	property p_min_delay;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == pcd_pkg::PCD_LOW) && !lock_r
		&& (tmr_r < `PCD_CNT_W'(`PCD_SHDN_MIN_CYC - 1)) |=> device_enabled;
	endproperty
	a_min_delay: assert property (p_min_delay) else $error("early shutdown");

	property p_hold_low;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == pcd_pkg::PCD_LOW) && !pin_lvl |=> $stable(count_r) || lock_r || !device_enabled;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("level moved while low");

	property p_tmr_clear;
		@(posedge clk_sys) disable iff (!reset_n)
		pin_edge |=> tmr_r == '0;
	endproperty
	a_tmr_clear: assert property (p_tmr_clear) else $error("timer not cleared");
endmodule // pcd_decoder
`default_nettype wire

// File: pcd_host_model.sv
// host gpio model driving the dimming pin
// assumes the bench calls its tasks; pin changes only at falling edges
`timescale 1ns/10ps
`default_nettype none

module pcd_host
(
	// clock
	input wire logic clk_sys,
	// dimming pin
	output var logic pin_out
);
	////////////////////////////////////////////////////////////////
	initial pin_out = 1'b0;

	// hold a level for a number of cycles
	task automatic drive(input logic lvl, input int cyc);
		@(negedge clk_sys);
		pin_out = lvl;
		repeat (cyc) @(negedge clk_sys);
	endtask

	// 10 us of high before any pulse
	task automatic enable();
		drive(1'b1, 250);
	endtask

	// one pulse; low width in cycles, high long enough to settle
	task automatic pulse(input int lo);
		drive(1'b0, lo);
		drive(1'b1, 30);
	endtask
endmodule // pcd_host

`default_nettype wire

// File: testbench.sv
// self-checking bench for the dimming decoder
// assumes the typical shutdown count; the one shutdown dominates the run time
`timescale 1ns/10ps
`default_nettype none
`include "pcd_defines.svh"

module testbench;
	// a shorter count would break the minimum shutdown delay that the design guards
	localparam int SHDN = `PCD_SHDN_TYP_CYC;
	logic clk_sys;
	logic reset_n;
	logic pin;
	logic lockout;
	logic [`PCD_LVL_W-1:0] code;
	logic [3:0] sink;
	logic en;
	logic [9:0] st;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	assign st = {en, sink, code};

	////////////////////////////////////////////////////////////////
	pcd_host pcd_host_i (.clk_sys(clk_sys), .pin_out(pin));

	pcd_decoder pcd_decoder_i
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.enable_dimming_input(pin),
		.supply_lockout(lockout),
		.current_code(code),
		.sink_enable(sink),
		.device_enabled(en)
	);

	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// enabled state after n counted pulses; 5 bits wrap 32 to full
	function automatic logic [9:0] on_lvl(input int n);
		return {1'b1, 4'hf, 5'(31 - n)};
	endfunction

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_enable();
		chk(st, 10'h000);
		pcd_host_i.enable();
		chk(st, on_lvl(0));
		$display("t_enable done");
	endtask

	task automatic t_steps();
		for (int n = 1; n <= 32; n++)
		begin
			pcd_host_i.pulse(30);
			chk(st, on_lvl(n));
		end
		$display("t_steps done");
	endtask

	// short lows are dropped, level holds
	task automatic t_glitch();
		pcd_host_i.pulse(30);
		pcd_host_i.pulse(10);
		chk(st, on_lvl(1));
		$display("t_glitch done");
	endtask

	task automatic t_shdn();
		pcd_host_i.drive(1'b0, SHDN - 60);
		chk(st, on_lvl(1));
		pcd_host_i.drive(1'b0, 100);
		chk(st, 10'h000);
		pcd_host_i.enable();
		chk(st, on_lvl(0));
		$display("t_shdn done");
	endtask

	// lockout with pin high: off, then back at full with count cleared
	task automatic t_lockout();
		pcd_host_i.pulse(30);
		pcd_host_i.pulse(30);
		chk(st, on_lvl(2));
		@(negedge clk_sys);
		lockout = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk(st, 10'h000);
		lockout = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk(st, on_lvl(0));
		pcd_host_i.pulse(30);
		chk(st, on_lvl(1));
		$display("t_lockout done");
	endtask

	////////////////////////////////////////////////////////////////
	// hang guard; the run needs about 78000 cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_errors++;
			test_done();
		end
	end

	initial
	begin
		reset_n = 1'b0;
		lockout = 1'b0;
		repeat (5) @(negedge clk_sys);
		reset_n = 1'b1;
		// lockout synchroniser leaves reset at 1
		repeat (8) @(negedge clk_sys);
		t_enable();
		t_steps();
		t_glitch();
		t_shdn();
		t_lockout();
		test_done();
	end
endmodule // testbench

`default_nettype wire
